// file: src/port_mux_fifo.sv
// dual clock fifo with gray pointers between sys and link domains
`timescale 1ns/1ps
`default_nettype none
module port_mux_fifo #(
	parameter int WIDTH = 5,
	parameter int DEPTH = 8
) (
	input wire logic wclk, // write clock
	input wire logic wrst, // write reset, active high
	input wire logic in_valid, // word offered
	output logic in_ready, // room available
	input wire logic [WIDTH-1:0] in_data, // word in
	input wire logic rclk, // read clock
	input wire logic rrst, // read reset, active high
	output logic out_valid, // word on out_data
	input wire logic out_ready, // consumer takes word
	output logic [WIDTH-1:0] out_data // word out
);
	localparam int AW = $clog2(DEPTH);
	initial begin
		if (DEPTH < 4 || (1 << AW) != DEPTH) begin
			$error("fifo depth must be a power of two, at least four");
		end
	end

	function automatic logic [AW:0] to_gray(input logic [AW:0] b);
		return b ^ (b >> 1);
	endfunction : to_gray

	logic [AW:0] wbin_reg, wgray_reg, rbin_reg, rgray_reg;
	logic [AW:0] rg_s1_reg, rg_s2_reg, wg_s1_reg, wg_s2_reg;
	logic [AW:0] rbin_next;
	logic mem_valid_reg;
	logic take;
	logic load;
	logic [WIDTH-1:0] mem_q;

	assign in_ready = to_gray(wbin_reg) !=
		{~rg_s2_reg[AW:AW-1], rg_s2_reg[AW-2:0]};
	always_ff @(posedge wclk or posedge wrst) begin
		if (wrst) begin
			wbin_reg <= '0;
			wgray_reg <= '0;
		end else if (in_valid && in_ready) begin
			wbin_reg <= wbin_reg + 1'b1;
			wgray_reg <= to_gray(wbin_reg + 1'b1);
		end
	end
	always_ff @(posedge wclk or posedge wrst) begin
		if (wrst) begin
			rg_s1_reg <= '0;
			rg_s2_reg <= '0;
		end else begin
			rg_s1_reg <= rgray_reg;
			rg_s2_reg <= rg_s1_reg;
		end
	end
	always_ff @(posedge rclk or posedge rrst) begin
		if (rrst) begin
			wg_s1_reg <= '0;
			wg_s2_reg <= '0;
		end else begin
			wg_s1_reg <= wgray_reg;
			wg_s2_reg <= wg_s1_reg;
		end
	end

	// one-word output stage fed by the registered memory read
	assign take = out_valid && out_ready;
	assign load = (to_gray(rbin_reg) != wg_s2_reg) && (!mem_valid_reg || take);
	assign rbin_next = rbin_reg + 1'b1;
	always_ff @(posedge rclk or posedge rrst) begin
		if (rrst) begin
			rbin_reg <= '0;
			rgray_reg <= '0;
			mem_valid_reg <= 1'b0;
		end else begin
			if (load) begin
				rbin_reg <= rbin_next;
				rgray_reg <= to_gray(rbin_next);
			end
			if (load) begin
				mem_valid_reg <= 1'b1;
			end else if (take) begin
				mem_valid_reg <= 1'b0;
			end
		end
	end
	assign out_valid = mem_valid_reg;
	assign out_data = mem_q;

	port_mux_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_mem (
		.clk(wclk),
		.wr_en(in_valid && in_ready),
		.wr_addr(wbin_reg[AW-1:0]),
		.wr_data(in_data),
		.rd_clk(rclk),
		.rd_addr(rbin_reg[AW-1:0]),
		.rd_en(load),
		.rd_data(mem_q)
	);
endmodule : port_mux_fifo
`default_nettype wire

// file: src/port_mux_mem.sv
// small register-read memory used as fifo storage
`timescale 1ns/1ps
`default_nettype none
module port_mux_mem #(
	parameter int WIDTH = 5,
	parameter int DEPTH = 8,
	parameter int AW = $clog2(DEPTH)
) (
	input wire logic clk, // write clock
	input wire logic wr_en, // write strobe
	input wire logic [AW-1:0] wr_addr, // write address
	input wire logic [WIDTH-1:0] wr_data, // write data
	input wire logic rd_clk, // read clock
	input wire logic [AW-1:0] rd_addr, // read address
	input wire logic rd_en, // load rd_data this edge
	output logic [WIDTH-1:0] rd_data // registered read data
);
	logic [WIDTH-1:0] store [DEPTH];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			store[wr_addr] <= wr_data;
		end
	end

	// read data holds while the consumer still shows it
	always_ff @(posedge rd_clk) begin
		if (rd_en) begin
			rd_data <= store[rd_addr];
		end
	end
endmodule : port_mux_mem
`default_nettype wire

// file: src/port_mux_pkg.sv
// shared constants and carrier types for the port one output mux
package port_mux_pkg;
	localparam logic [2:0] STRAP_MII_MAC = 3'h0;
	localparam logic [2:0] STRAP_MII_PHY = 3'h1;
	localparam logic [2:0] STRAP_TURBO_WEAK = 3'h2;
	localparam logic [2:0] STRAP_TURBO_STRONG = 3'h3;
	localparam logic [2:0] STRAP_RMII_OUT_WEAK = 3'h4;
	localparam logic [2:0] STRAP_RMII_OUT_STRONG = 3'h5;
	localparam logic [2:0] STRAP_RMII_IN = 3'h6;
	localparam logic [2:0] STRAP_INTERNAL = 3'h7;
	localparam logic [2:0] STRAP_RESET = 3'h7;
	localparam int NIBBLE_W = 4;
	localparam int DIBIT_W = 2;
	localparam int FIFO_DEPTH = 8;
	localparam int CLK_SYS_HZ = 50000000;
	localparam int RMII_REF_HZ = 50000000;
	localparam int RMII_REF_DIV = CLK_SYS_HZ / RMII_REF_HZ;

	typedef enum {
		ROLE_MII_MAC,
		ROLE_MII_PHY,
		ROLE_RMII_PHY,
		ROLE_INTERNAL
	} role_type;

	typedef struct packed {
		logic last;
		logic [NIBBLE_W-1:0] data;
	} nibble_type;

	typedef struct packed {
		logic turbo;
		logic clock_strong;
		logic clock_out;
	} clock_cfg_type;
endpackage : port_mux_pkg

// file: src/port_one_mii_output_mode_mux.sv
// mode-steered transmit-direction pins of the second switch port
`timescale 1ns/1ps
`default_nettype none
module port_one_mii_output_mode_mux
	import port_mux_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic clk_sys, // switch core clock
	input wire logic rst, // async reset, active high
	input wire logic port_role_strap_bit2, // mode strap, bit 2
	input wire logic port_role_strap_bit1, // mode strap, bit 1
	input wire logic port_role_strap_bit0, // mode strap, bit 0
	input wire logic port_isolate, // isolate control bit
	input wire logic tx_valid, // nibble offered by switch
	output logic tx_ready, // fifo has room and a non-internal role is latched
	input wire port_mux_pkg::nibble_type tx_word, // nibble and end mark
	input wire logic link_clk, // port reference clock
	output logic [NIBBLE_W-1:0] port_out_data, // data pin levels
	output logic [NIBBLE_W-1:0] port_out_data_oe_n, // data enables, low drives
	output logic port_out_valid, // valid pin level
	output logic port_out_valid_oe_n, // valid enable, low drives
	output logic port_out_ref_clock, // ref clock pin level
	output logic port_out_ref_clock_oe_n, // ref clock enable, low drives
	output var port_mux_pkg::clock_cfg_type clock_cfg, // latched clock setup
	output var port_mux_pkg::role_type port_role // latched role
);
	import port_mux_pkg::*;

	initial begin
		if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) begin
			$error("depth must be a power of two, at least four");
		end
	end

	function automatic role_type decode_role(input logic [2:0] code);
		unique case (code)
			STRAP_MII_MAC: return ROLE_MII_MAC;
			STRAP_MII_PHY, STRAP_TURBO_WEAK, STRAP_TURBO_STRONG:
				return ROLE_MII_PHY;
			STRAP_RMII_OUT_WEAK, STRAP_RMII_OUT_STRONG, STRAP_RMII_IN:
				return ROLE_RMII_PHY;
			STRAP_INTERNAL: return ROLE_INTERNAL;
		endcase
	endfunction : decode_role

	function automatic clock_cfg_type decode_clock(input logic [2:0] code);
		clock_cfg_type c;
		c.turbo = (code == STRAP_TURBO_WEAK) || (code == STRAP_TURBO_STRONG);
		c.clock_strong = (code == STRAP_TURBO_STRONG) ||
			(code == STRAP_RMII_OUT_STRONG);
		c.clock_out = c.turbo || (code == STRAP_RMII_OUT_WEAK) ||
			(code == STRAP_RMII_OUT_STRONG);
		return c;
	endfunction : decode_clock

	// straps are pins: two stages, then caught once after release
	logic [2:0] strap_s1_reg, strap_s2_reg;
	logic strap_done_reg;
	logic [2:0] strap_code_reg;
	logic iso_s1_reg, iso_s2_reg;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			strap_s1_reg <= STRAP_RESET;
			strap_s2_reg <= STRAP_RESET;
			iso_s1_reg <= 1'b0;
			iso_s2_reg <= 1'b0;
		end else begin
			strap_s1_reg <= {port_role_strap_bit2, port_role_strap_bit1,
				port_role_strap_bit0};
			strap_s2_reg <= strap_s1_reg;
			iso_s1_reg <= port_isolate;
			iso_s2_reg <= iso_s1_reg;
		end
	end

	// latch on the third edge so both sync stages hold real pin levels
	logic [1:0] settle_reg;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			settle_reg <= 2'h0;
			strap_done_reg <= 1'b0;
			strap_code_reg <= STRAP_RESET;
		end else if (!strap_done_reg) begin
			if (settle_reg == 2'h2) begin
				strap_code_reg <= strap_s2_reg;
				strap_done_reg <= 1'b1;
			end else begin
				settle_reg <= settle_reg + 2'h1;
			end
		end
	end
	assign port_role = strap_done_reg ? decode_role(strap_code_reg) :
		ROLE_INTERNAL;
	assign clock_cfg = decode_clock(strap_code_reg);

	// link domain reset: released by a two-stage synchroniser
	logic lrst_s1_reg, lrst_reg;
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			lrst_s1_reg <= 1'b1;
			lrst_reg <= 1'b1;
		end else begin
			lrst_s1_reg <= 1'b0;
			lrst_reg <= lrst_s1_reg;
		end
	end

	// done crosses through two stages; the code word is sampled only
	// once done has settled, when it can no longer be moving
	logic [2:0] lcode_reg;
	logic ldone_s1_reg, ldone_s2_reg, ldone_reg;
	logic liso_s1_reg, liso_reg;
	always_ff @(posedge link_clk or posedge lrst_reg) begin
		if (lrst_reg) begin
			lcode_reg <= STRAP_RESET;
			ldone_s1_reg <= 1'b0;
			ldone_s2_reg <= 1'b0;
			ldone_reg <= 1'b0;
			liso_s1_reg <= 1'b0;
			liso_reg <= 1'b0;
		end else begin
			if (ldone_s2_reg && !ldone_reg) begin
				lcode_reg <= strap_code_reg;
			end
			ldone_s1_reg <= strap_done_reg;
			ldone_s2_reg <= ldone_s1_reg;
			ldone_reg <= ldone_s2_reg;
			liso_s1_reg <= iso_s2_reg;
			liso_reg <= liso_s1_reg;
		end
	end
	role_type lrole;
	assign lrole = ldone_reg ? decode_role(lcode_reg) : ROLE_INTERNAL;

	// nibble path: sys side fills, link side drains
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	nibble_type fifo_out_word;
	logic accept_sys;
	assign accept_sys = strap_done_reg &&
		(decode_role(strap_code_reg) != ROLE_INTERNAL);
	assign tx_ready = fifo_in_ready && accept_sys;

	port_mux_fifo #(.WIDTH(NIBBLE_W + 1), .DEPTH(DEPTH)) u_fifo (
		.wclk(clk_sys),
		.wrst(rst),
		.in_valid(tx_valid && accept_sys),
		.in_ready(fifo_in_ready),
		.in_data(tx_word),
		.rclk(link_clk),
		.rrst(lrst_reg),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_word)
	);

	// rmii sends each nibble as two dibits, low pair first
	logic half_reg;
	logic lane_active;
	logic [NIBBLE_W-1:0] data_next;
	logic valid_next;
	assign lane_active = (lrole != ROLE_INTERNAL) &&
		!(liso_reg && lrole != ROLE_MII_MAC);
	assign fifo_out_ready = lane_active && fifo_out_valid &&
		(lrole != ROLE_RMII_PHY || half_reg);

	always_comb begin
		data_next = '0;
		valid_next = 1'b0;
		if (lane_active && fifo_out_valid) begin
			unique case (lrole)
				ROLE_MII_MAC: begin
					data_next = fifo_out_word.data;
					valid_next = 1'b1;
				end
				ROLE_MII_PHY: begin
					data_next = fifo_out_word.data;
					valid_next = 1'b1;
				end
				ROLE_RMII_PHY: begin
					data_next[DIBIT_W-1:0] = half_reg ?
						fifo_out_word.data[NIBBLE_W-1:DIBIT_W] :
						fifo_out_word.data[DIBIT_W-1:0];
					valid_next = 1'b1;
				end
				ROLE_INTERNAL: begin
					data_next = '0;
					valid_next = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge link_clk or posedge lrst_reg) begin
		if (lrst_reg) begin
			half_reg <= 1'b0;
		end else if (lrole != ROLE_RMII_PHY || !lane_active) begin
			half_reg <= 1'b0;
		end else if (fifo_out_valid) begin
			half_reg <= ~half_reg;
		end
	end

	always_ff @(posedge link_clk or posedge lrst_reg) begin
		if (lrst_reg) begin
			port_out_data <= '0;
			port_out_valid <= 1'b0;
		end else begin
			port_out_data <= data_next;
			port_out_valid <= valid_next;
		end
	end

	// enables: internal or isolated phy roles release the pins
	logic data_drive;
	logic upper_drive;
	assign data_drive = lane_active;
	assign upper_drive = lane_active && lrole != ROLE_RMII_PHY;
	genvar gi;
	generate
		for (gi = 0; gi < NIBBLE_W; gi++) begin : g_oe
			if (gi < DIBIT_W) begin : g_low
				assign port_out_data_oe_n[gi] = ~data_drive;
			end else begin : g_up
				assign port_out_data_oe_n[gi] = ~upper_drive;
			end
		end
	endgenerate
	assign port_out_valid_oe_n = ~data_drive;

	// forwarded ref clock for roles that drive it; mac role takes it in
	logic clk_drive;
	clock_cfg_type lclk_cfg;
	assign lclk_cfg = decode_clock(lcode_reg);
	assign clk_drive = ldone_reg && lclk_cfg.clock_out &&
		!liso_reg;
	assign port_out_ref_clock_oe_n = ~clk_drive;
	assign port_out_ref_clock = clk_drive & link_clk;

	property p_valid_follows_fifo;
		@(posedge link_clk) disable iff (lrst_reg)
		(lane_active && fifo_out_valid) |=> port_out_valid;
	endproperty
	a_valid_follows_fifo: assert property (p_valid_follows_fifo)
		else $error("valid not raised for queued data");
	property p_idle_low;
		@(posedge link_clk) disable iff (lrst_reg)
		!fifo_out_valid |=> !port_out_valid && port_out_data == '0;
	endproperty
	a_idle_low: assert property (p_idle_low)
		else $error("idle lane not quiet");
	property p_isolate_release;
		@(posedge link_clk) disable iff (lrst_reg)
		(liso_reg && lrole != ROLE_MII_MAC) |->
			port_out_valid_oe_n && port_out_data_oe_n == '1;
	endproperty
	a_isolate_release: assert property (p_isolate_release)
		else $error("isolated pins driven");
	logic tx_fifo_pull;
	assign tx_fifo_pull = fifo_out_ready;
	property p_internal_idle;
		@(posedge link_clk) disable iff (lrst_reg)
		(lrole == ROLE_INTERNAL) [*2] |-> !port_out_valid && !tx_fifo_pull;
	endproperty
	a_internal_idle: assert property (p_internal_idle)
		else $error("traffic in internal mode");
	property p_internal_pins;
		@(posedge link_clk) disable iff (lrst_reg)
		(lrole == ROLE_INTERNAL) |-> port_out_valid_oe_n &&
			port_out_data_oe_n == '1 && port_out_ref_clock_oe_n;
	endproperty
	a_internal_pins: assert property (p_internal_pins)
		else $error("internal mode drives port pins");
	property p_rmii_upper;
		@(posedge link_clk) disable iff (lrst_reg)
		(lrole == ROLE_RMII_PHY) |-> port_out_data_oe_n[NIBBLE_W-1:DIBIT_W] == '1;
	endproperty
	a_rmii_upper: assert property (p_rmii_upper)
		else $error("rmii upper lines driven");
	sequence s_mii_send;
		(lrole == ROLE_MII_MAC || lrole == ROLE_MII_PHY) && lane_active &&
			fifo_out_valid;
	endsequence
	property p_mii_data;
		@(posedge link_clk) disable iff (lrst_reg)
		s_mii_send |=> port_out_data == $past(fifo_out_word.data);
	endproperty
	a_mii_data: assert property (p_mii_data)
		else $error("mii nibble not passed through");
	sequence s_rmii_first;
		lrole == ROLE_RMII_PHY && lane_active && fifo_out_valid && !half_reg;
	endsequence
	property p_rmii_pair;
		@(posedge link_clk) disable iff (lrst_reg)
		s_rmii_first |=> half_reg && port_out_valid;
	endproperty
	a_rmii_pair: assert property (p_rmii_pair)
		else $error("rmii dibit pairing broken");
	property p_rmii_dibits;
		@(posedge link_clk) disable iff (lrst_reg)
		s_rmii_first ##1 lane_active |=> port_out_data[DIBIT_W-1:0] ==
			$past(fifo_out_word.data[NIBBLE_W-1:DIBIT_W], 2);
	endproperty
	a_rmii_dibits: assert property (p_rmii_dibits)
		else $error("rmii upper dibit not from the same nibble");
	property p_mac_clock_in;
		@(posedge link_clk) disable iff (lrst_reg)
		(lrole == ROLE_MII_MAC) |-> port_out_ref_clock_oe_n;
	endproperty
	a_mac_clock_in: assert property (p_mac_clock_in)
		else $error("mac role drives the port clock");
	property p_role_fixed;
		@(posedge clk_sys) disable iff (rst)
		strap_done_reg |=> $stable(strap_code_reg) && strap_done_reg;
	endproperty
	a_role_fixed: assert property (p_role_fixed)
		else $error("role changed after latch");
	property p_latch_time;
		@(posedge clk_sys) disable iff (rst)
		$rose(strap_done_reg) |-> strap_code_reg == $past(strap_s2_reg);
	endproperty
	a_latch_time: assert property (p_latch_time)
		else $error("strap latched wrong value");
	property p_clock_dir;
		@(posedge clk_sys) disable iff (rst)
		(strap_done_reg && strap_code_reg == STRAP_RMII_IN) |->
			!clock_cfg.clock_out;
	endproperty
	a_clock_dir: assert property (p_clock_dir)
		else $error("rmii input clock driven");
	property p_turbo_clock;
		@(posedge clk_sys) disable iff (rst)
		(strap_done_reg && (strap_code_reg == STRAP_TURBO_WEAK ||
			strap_code_reg == STRAP_TURBO_STRONG)) |-> clock_cfg.turbo &&
			clock_cfg.clock_out &&
			clock_cfg.clock_strong == (strap_code_reg == STRAP_TURBO_STRONG);
	endproperty
	a_turbo_clock: assert property (p_turbo_clock)
		else $error("turbo clock setup wrong");
endmodule : port_one_mii_output_mode_mux
`default_nettype wire

// file: tb/link_far_end.sv
// far-end mac or phy: makes the port clock, collects nibbles from the pins
`timescale 1ns/1ps
`default_nettype none
module link_far_end
	import port_mux_pkg::*;
(
	output logic link_clk, // free-running port reference clock
	input wire logic rmii, // pair dibits into nibbles
	input wire logic [NIBBLE_W-1:0] pin_data, // data pin levels
	input wire logic [NIBBLE_W-1:0] pin_data_oe_n, // data enables, low drives
	input wire logic pin_valid, // valid pin level
	input wire logic pin_valid_oe_n, // valid enable, low drives
	output logic [NIBBLE_W-1:0] got_data, // last nibble collected
	output int got_count // nibbles collected so far
);
	logic [NIBBLE_W-1:0] wire_data;
	logic [NIBBLE_W-1:0] last_data;
	logic [1:0] low_half;
	logic half;
	logic wire_valid;
	initial begin
		got_count = 0;
		got_data = 4'h0;
		last_data = 4'h0;
		low_half = 2'h0;
		half = 1'b0;
		link_clk = 1'b0;
		#3.1;
		forever #7.5 link_clk = ~link_clk;
	end
	// a released data line floats: show the opposite of its last level
	always_comb begin
		for (int i = 0; i < NIBBLE_W; i++) begin
			wire_data[i] = pin_data_oe_n[i] ? ~last_data[i] : pin_data[i];
		end
	end
	// board pull-down keeps a released valid line low
	assign wire_valid = pin_valid_oe_n ? 1'b0 : pin_valid;
	always @(posedge link_clk) begin
		last_data <= wire_data;
		if (wire_valid !== 1'b1) begin
			half <= 1'b0;
		end else if (!rmii) begin
			got_data <= wire_data;
			got_count <= got_count + 1;
		end else if (!half) begin
			low_half <= wire_data[1:0];
			half <= 1'b1;
		end else begin
			got_data <= {wire_data[1:0], low_half};
			got_count <= got_count + 1;
			half <= 1'b0;
		end
	end
endmodule : link_far_end
`default_nettype wire

// file: tb/port_one_mii_output_mode_mux_test.sv
// self-checking bench: every strap code, traffic, isolate and fifo fill
`timescale 1ns/1ps
`default_nettype none
module port_one_mii_output_mode_mux_test;
	import port_mux_pkg::*;
	logic clk_sys, rst, link_clk, tx_valid, tx_ready, port_isolate, rmii;
	logic [2:0] strap;
	nibble_type tx_word;
	logic [3:0] out_data, out_data_oe_n, got_data;
	logic out_valid, out_valid_oe_n, ref_clock, ref_clock_oe_n;
	clock_cfg_type clock_cfg;
	role_type port_role;
	int got_count, n_errors, n_tests;
	logic [3:0] exp_q[$];

	port_one_mii_output_mode_mux port_one_mii_output_mode_mux_i (
		.clk_sys(clk_sys), .rst(rst),
		.port_role_strap_bit2(strap[2]), .port_role_strap_bit1(strap[1]),
		.port_role_strap_bit0(strap[0]), .port_isolate(port_isolate),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_word(tx_word),
		.link_clk(link_clk), .port_out_data(out_data),
		.port_out_data_oe_n(out_data_oe_n), .port_out_valid(out_valid),
		.port_out_valid_oe_n(out_valid_oe_n), .port_out_ref_clock(ref_clock),
		.port_out_ref_clock_oe_n(ref_clock_oe_n), .clock_cfg(clock_cfg),
		.port_role(port_role));
	link_far_end link_far_end_i (.link_clk(link_clk), .rmii(rmii),
		.pin_data(out_data), .pin_data_oe_n(out_data_oe_n),
		.pin_valid(out_valid), .pin_valid_oe_n(out_valid_oe_n),
		.got_data(got_data), .got_count(got_count));

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	function automatic role_type exp_role(input logic [2:0] c);
		case (c)
			3'h0: return ROLE_MII_MAC;
			3'h1, 3'h2, 3'h3: return ROLE_MII_PHY;
			3'h7: return ROLE_INTERNAL;
			default: return ROLE_RMII_PHY;
		endcase
	endfunction : exp_role

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : end_sim

	task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_val

	task automatic check_role(input role_type got, input role_type exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_role

	task automatic hang(input string what);
		n_errors++;
		$display("Error at %0t: timeout in %s", $time, what);
		end_sim;
	endtask : hang

	// every nibble the far end collects must be the next one sent
	always @(got_count) begin
		#1;
		if (exp_q.size() == 0) check_val(8'(got_data), 8'hff);
		else check_val(8'(got_data), 8'(exp_q.pop_front()));
	end

	task automatic send_burst(input int n, output int stalls);
		int k;
		stalls = 0;
		for (int i = 0; i < n; i++) begin
			@(negedge clk_sys);
			tx_valid = 1'b1;
			tx_word.data = 4'($urandom);
			tx_word.last = (i == n - 1);
			k = 0;
			while (tx_ready !== 1'b1 && k < 200) begin
				stalls++;
				k++;
				@(negedge clk_sys);
			end
			if (k == 200) hang("send");
			@(posedge clk_sys);
			exp_q.push_back(tx_word.data);
		end
		@(negedge clk_sys);
		tx_valid = 1'b0;
	endtask : send_burst

	task automatic run_mode(input logic [2:0] code);
		int stalls;
		int k;
		logic phy;
		logic clk_out;
		phy = (code != 3'h0);
		clk_out = code inside {3'h2, 3'h3, 3'h4, 3'h5};
		@(negedge clk_sys);
		rst = 1'b1;
		strap = code;
		rmii = (exp_role(code) == ROLE_RMII_PHY);
		repeat (8) @(negedge clk_sys);
		check_val({3'h0, out_data_oe_n, out_valid_oe_n}, 8'h1f);
		rst = 1'b0;
		repeat (8) @(negedge clk_sys);
		check_role(port_role, exp_role(code));
		check_val(8'({clock_cfg.turbo, clock_cfg.clock_strong}),
			8'({code[2:1] == 2'h1, code == 3'h3 || code == 3'h5}));
		check_val(8'({clock_cfg.clock_out, ref_clock_oe_n}),
			clk_out ? 8'h02 : 8'h01);
		@(posedge link_clk);
		#1;
		check_val(8'(ref_clock), 8'(clk_out));
		@(negedge clk_sys);
		check_val({3'h0, out_data_oe_n, out_valid_oe_n},
			(code == 3'h7) ? 8'h1f : (rmii ? 8'h18 : 8'h00));
		strap = ~code;
		repeat (10) @(negedge clk_sys);
		check_role(port_role, exp_role(code));
		if (code == 3'h7) begin
			check_val(8'(tx_ready), 8'h00);
		end else begin
			send_burst(24, stalls);
			if (rmii) check_val(8'(stalls > 0), 8'h01);
			k = 0;
			while (exp_q.size() != 0 && k < 400) begin
				k++;
				@(negedge clk_sys);
			end
			if (k == 400) hang("drain");
			repeat (4) @(negedge clk_sys);
			check_val(8'(out_valid), 8'h00);
			port_isolate = 1'b1;
			repeat (10) @(negedge clk_sys);
			check_val({2'h0, tx_ready, out_data_oe_n, out_valid_oe_n},
				phy ? 8'h3f : 8'h20);
			check_val(8'(ref_clock_oe_n), 8'h01);
			port_isolate = 1'b0;
			repeat (10) @(negedge clk_sys);
		end
		$display("mode %0d done", code);
	endtask : run_mode

	initial begin
		n_errors = 0;
		n_tests = 0;
		rst = 1'b1;
		strap = 3'h7;
		port_isolate = 1'b0;
		tx_valid = 1'b0;
		tx_word = '0;
		rmii = 1'b0;
		void'($urandom(1634));
		for (int c = 0; c < 8; c++) run_mode(3'(c));
		end_sim;
	end
endmodule : port_one_mii_output_mode_mux_test
`default_nettype wire
